// ==== core/ipc_top.sv ====
`timescale 1ns/10ps
// How it works
// [RULE1] First single-ended rank in se bits 3:0
// [RULE2] Second differential rank in diff bits 7:4
// [RULE3] Zero second differential rank means unavailable
// [RULE4] Nonzero second diff write clears second se
// [RULE5] First differential rank in diff bits 3:0
// [RULE6] Zero first differential rank means unavailable
// [RULE7] Nonzero first diff write clears first se
// [RULE8] Reset: se reads 0x32, diff reads 0x00
// [RULE9] Pick smallest nonzero rank among valid inputs
module ipc_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ipc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [ipc_pkg::DAT_W-1:0] wb_dat_i,
    output logic [ipc_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [ipc_pkg::NUM_INPUTS-1:0] input_valid_i,
    output logic selected_valid_o,
    output logic [1:0] selected_input_o
);
    logic [7:0] se_rank;
    logic [7:0] diff_rank;
    logic [7:0] next_se_rank;
    logic [7:0] next_diff_rank;
    logic [ipc_pkg::DAT_W-1:0] next_dat;
    logic next_ack;
    logic next_sel_valid;
    logic [1:0] next_sel_input;
    logic [ipc_pkg::NUM_INPUTS-1:0] valid_sync;
    logic [ipc_pkg::NUM_INPUTS*ipc_pkg::RANK_W-1:0] ranks;
    logic pick_found;
    logic [1:0] pick_index;
    logic req;
    logic commit;
    logic [ipc_pkg::NUM_INPUTS-1:0] prev_valid;
    logic [ipc_pkg::NUM_INPUTS*ipc_pkg::RANK_W-1:0] prev_ranks;

    // Word index decode, used for both reads and writes
    function automatic logic hit(input logic [ipc_pkg::ADR_W-1:0] adr, input logic [7:0] idx);
        return (adr[ipc_pkg::ADR_W-1:2] == idx) && (adr[1:0] == 2'h0);
    endfunction

    function automatic logic nonzero(input logic [3:0] rank);
        return rank != ipc_pkg::RANK_OFF;
    endfunction

    // Valid levels come from monitors outside this clock
    ipc_sync2 #(
        .WIDTH(ipc_pkg::NUM_INPUTS)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(input_valid_i),
        .sync_o(valid_sync)
    );

    // Candidate ranks in input-index order
    assign ranks = {diff_rank[ipc_pkg::SECOND_LSB +: ipc_pkg::RANK_W],
                    diff_rank[ipc_pkg::FIRST_LSB +: ipc_pkg::RANK_W],
                    se_rank[ipc_pkg::SECOND_LSB +: ipc_pkg::RANK_W],
                    se_rank[ipc_pkg::FIRST_LSB +: ipc_pkg::RANK_W]};

    ipc_rank_pick u_pick (
        .valid_i(valid_sync),
        .ranks_i(ranks),
        .found_o(pick_found),
        .index_o(pick_index)
    );

    // Ack one cycle after the request; a write lands on the acked edge
    assign req = wb_cyc_i && wb_stb_i;
    assign commit = req && wb_ack_o && wb_we_i && wb_sel_i[0];

    // Bus and register next values
    always_comb begin
        next_ack = req && !wb_ack_o;
        next_dat = wb_dat_o;
        next_se_rank = se_rank;
        next_diff_rank = diff_rank;
        if (next_ack) begin
            next_dat = '0;
            if (hit(wb_adr_i, ipc_pkg::IDX_SE_RANK)) begin
                next_dat[7:0] = se_rank;
            end else if (hit(wb_adr_i, ipc_pkg::IDX_DIFF_RANK)) begin
                next_dat[7:0] = diff_rank;
            end else if (hit(wb_adr_i, ipc_pkg::IDX_STATUS)) begin
                next_dat[ipc_pkg::STS_IDX_LSB +: 2] = selected_input_o;
                next_dat[ipc_pkg::STS_FOUND_BIT] = selected_valid_o;
                next_dat[ipc_pkg::STS_VALID_LSB +: ipc_pkg::NUM_INPUTS] = valid_sync;
            end
        end
        if (commit && hit(wb_adr_i, ipc_pkg::IDX_SE_RANK)) begin
            next_se_rank = wb_dat_i[7:0]; // see [RULE1]
        end
        if (commit && hit(wb_adr_i, ipc_pkg::IDX_DIFF_RANK)) begin
            next_diff_rank = wb_dat_i[7:0]; // see [RULE2] see [RULE5]
            // Twin inputs share a pin pair, so the TTL twin is switched off
            if (nonzero(wb_dat_i[ipc_pkg::SECOND_LSB +: ipc_pkg::RANK_W])) begin
                next_se_rank[ipc_pkg::SECOND_LSB +: ipc_pkg::RANK_W] = ipc_pkg::RANK_OFF; // see [RULE4]
            end
            if (nonzero(wb_dat_i[ipc_pkg::FIRST_LSB +: ipc_pkg::RANK_W])) begin
                next_se_rank[ipc_pkg::FIRST_LSB +: ipc_pkg::RANK_W] = ipc_pkg::RANK_OFF; // see [RULE7]
            end
        end
    end

    // Selection is registered so the status read is glitch free
    always_comb begin
        next_sel_valid = pick_found; // see [RULE9] see [RULE3] see [RULE6]
        next_sel_input = pick_found ? pick_index : 2'h0;
    end

    // Picker inputs one edge back, so checks index them by the current selection
    always_ff @(posedge clk_i) begin
        prev_valid <= valid_sync;
        prev_ranks <= ranks;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            se_rank <= ipc_pkg::RST_SE_RANK; // see [RULE8]
            diff_rank <= ipc_pkg::RST_DIFF_RANK; // see [RULE8]
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            selected_valid_o <= 1'b0;
            selected_input_o <= 2'h0;
        end else begin
            se_rank <= next_se_rank;
            diff_rank <= next_diff_rank;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
            selected_valid_o <= next_sel_valid;
            selected_input_o <= next_sel_input;
        end
    end

    // Checks
    logic wr_se;
    logic wr_diff;
    assign wr_se = commit && hit(wb_adr_i, ipc_pkg::IDX_SE_RANK);
    assign wr_diff = commit && hit(wb_adr_i, ipc_pkg::IDX_DIFF_RANK);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    reset_values_a: assert property ($past(rst_i) |-> se_rank == 8'h32 && diff_rank == 8'h00) // see [RULE8]
        else $error("rank registers not at reset values");

    se_first_store_a: assert property (wr_se |=> se_rank[3:0] == $past(wb_dat_i[3:0])) // see [RULE1]
        else $error("first single-ended rank not stored");

    diff_second_store_a: assert property (wr_diff |=> diff_rank[7:4] == $past(wb_dat_i[7:4])) // see [RULE2]
        else $error("second differential rank not stored");

    diff_first_store_a: assert property (wr_diff |=> diff_rank[3:0] == $past(wb_dat_i[3:0])) // see [RULE5]
        else $error("first differential rank not stored");

    second_twin_off_a: assert property (wr_diff && wb_dat_i[7:4] != 4'h0 |=> se_rank[7:4] == 4'h0) // see [RULE4]
        else $error("second single-ended rank not cleared");

    first_twin_off_a: assert property (wr_diff && wb_dat_i[3:0] != 4'h0 |=> se_rank[3:0] == 4'h0) // see [RULE7]
        else $error("first single-ended rank not cleared");

    second_diff_off_a: assert property (selected_valid_o && selected_input_o == 2'h3
        |-> $past(diff_rank[7:4]) != 4'h0) // see [RULE3]
        else $error("second differential chosen with zero rank");

    first_diff_off_a: assert property (selected_valid_o && selected_input_o == 2'h2
        |-> $past(diff_rank[3:0]) != 4'h0) // see [RULE6]
        else $error("first differential chosen with zero rank");

    pick_smallest_a: assert property (selected_valid_o |-> prev_valid[selected_input_o] &&
        prev_ranks[selected_input_o*4 +: 4] != 4'h0 &&
        (!prev_valid[0] || prev_ranks[3:0] == 4'h0 ||
         prev_ranks[3:0] >= prev_ranks[selected_input_o*4 +: 4])) // see [RULE9]
        else $error("selection not the smallest usable rank");

    ack_pulse_a: assert property (req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a one-cycle answer");

    diff_clear_c: cover property (wr_diff && wb_dat_i[7:0] == 8'h11);
    pick_diff_c: cover property (selected_valid_o && selected_input_o == 2'h3);
    none_usable_c: cover property (!selected_valid_o && valid_sync == 4'hF);
    status_read_c: cover property (req && !wb_we_i && hit(wb_adr_i, ipc_pkg::IDX_STATUS) && wb_ack_o);
endmodule

// ==== core/ipc_pkg.sv ====
package ipc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_SE_RANK = 8'h19;
    localparam logic [7:0] IDX_DIFF_RANK = 8'h1A;
    localparam logic [7:0] IDX_STATUS = 8'h1B;
    // Reset values
    localparam logic [7:0] RST_SE_RANK = 8'h32;
    localparam logic [7:0] RST_DIFF_RANK = 8'h00;
    // Rank field layout inside each rank register
    localparam int RANK_W = 4;
    localparam int FIRST_LSB = 0;
    localparam int SECOND_LSB = 4;
    localparam logic [3:0] RANK_OFF = 4'h0;
    // Candidate inputs seen by the selector
    localparam int NUM_INPUTS = 4;
    localparam logic [1:0] IN_FIRST_SE = 2'h0;
    localparam logic [1:0] IN_SECOND_SE = 2'h1;
    localparam logic [1:0] IN_FIRST_DIFF = 2'h2;
    localparam logic [1:0] IN_SECOND_DIFF = 2'h3;
    // Status register layout
    localparam int STS_IDX_LSB = 0;
    localparam int STS_FOUND_BIT = 2;
    localparam int STS_VALID_LSB = 4;
    // Wishbone geometry
    localparam int ADR_W = 10;
    localparam int DAT_W = 32;
endpackage

// ==== core/ipc_sync2.sv ====
`timescale 1ns/10ps
// Two-flop synchroniser for asynchronous level inputs
module ipc_sync2 #(
    parameter int WIDTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;

    // First stage feeds only the second stage
    always_comb begin
        next_meta = async_i;
        next_sync = meta;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= '0;
            sync_o <= '0;
        end else begin
            meta <= next_meta;
            sync_o <= next_sync;
        end
    end
endmodule

// ==== core/ipc_rank_pick.sv ====
`timescale 1ns/10ps
// Picks the valid input with the smallest non-zero rank
module ipc_rank_pick (
    input wire logic [ipc_pkg::NUM_INPUTS-1:0] valid_i,
    input wire logic [ipc_pkg::NUM_INPUTS*ipc_pkg::RANK_W-1:0] ranks_i,
    output logic found_o,
    output logic [1:0] index_o
);
    logic [ipc_pkg::NUM_INPUTS-1:0] usable;
    logic [ipc_pkg::RANK_W-1:0] best;

    // A zero rank removes the input from the race
    genvar g;
    generate
        for (g = 0; g < ipc_pkg::NUM_INPUTS; g++) begin : g_use
            assign usable[g] = valid_i[g] &&
                (ranks_i[g*ipc_pkg::RANK_W +: ipc_pkg::RANK_W] != ipc_pkg::RANK_OFF);
        end
    endgenerate

    // Strict compare: on a tie the lower index keeps the slot
    always_comb begin
        found_o = 1'b0;
        index_o = 2'h0;
        best = 4'hF;
        for (int i = 0; i < ipc_pkg::NUM_INPUTS; i++) begin
            if (usable[i] && (!found_o || ranks_i[i*ipc_pkg::RANK_W +: ipc_pkg::RANK_W] < best)) begin
                found_o = 1'b1;
                index_o = i[1:0];
                best = ranks_i[i*ipc_pkg::RANK_W +: ipc_pkg::RANK_W];
            end
        end
    end
endmodule

// ==== testbench/tb_input_priority_config.sv ====
`timescale 1ns/10ps
module tb_input_priority_config;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [ipc_pkg::ADR_W-1:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [ipc_pkg::DAT_W-1:0] wb_dat_i = '0;
    logic [ipc_pkg::DAT_W-1:0] wb_dat_o;
    logic wb_ack_o;
    logic [ipc_pkg::NUM_INPUTS-1:0] input_valid_i = 4'h0;
    logic selected_valid_o;
    logic [1:0] selected_input_o;
    int errors = 0;
    int checked = 0;
    localparam logic [9:0] A_SE = {ipc_pkg::IDX_SE_RANK, 2'b00};
    localparam logic [9:0] A_DIFF = {ipc_pkg::IDX_DIFF_RANK, 2'b00};
    localparam logic [9:0] A_STS = {ipc_pkg::IDX_STATUS, 2'b00};

    // Free-running 100 MHz clock
    always #5 clk_i = ~clk_i;

    ipc_top DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .input_valid_i(input_valid_i),
        .selected_valid_o(selected_valid_o), .selected_input_o(selected_input_o)
    );

    task finish_test();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task chk32(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: register read %h, wanted %h", $time, got, exp);
        end
    endtask

    task chk_sel(input logic v, input logic [1:0] idx);
        checked++;
        if (selected_valid_o !== v || selected_input_o !== idx) begin
            errors++;
            $display("unexpected at %0t: selection %b/%0d, wanted %b/%0d", $time,
                selected_valid_o, selected_input_o, v, idx);
        end
    endtask

    // Single classic cycle; held until ack is sampled, bounded wait
    task wb(input logic we, input logic [9:0] adr, input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 20) begin
            errors++;
            $display("unexpected at %0t: no acknowledge", $time);
            finish_test();
        end
    endtask

    task rd_chk(input logic [9:0] adr, input logic [7:0] exp);
        logic [31:0] q;
        wb(1'b0, adr, 8'h00, q);
        chk32(q, {24'h000000, exp});
    endtask

    task wr(input logic [9:0] adr, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, adr, d, q);
    endtask

    // Valids pass two sync flops plus the output register
    task sel_chk(input logic [3:0] vin, input logic v, input logic [1:0] idx);
        @(posedge clk_i);
        input_valid_i <= vin;
        repeat (4) @(posedge clk_i);
        chk_sel(v, idx);
    endtask

    task t_reset();
        rd_chk(A_SE, ipc_pkg::RST_SE_RANK);
        rd_chk(A_DIFF, 8'h00);
        sel_chk(4'h3, 1'b1, 2'h0);
    endtask

    // Unmapped and misaligned places: reads zero, writes dropped
    task t_unmapped();
        rd_chk(10'h3FC, 8'h00);
        wr(A_SE | 10'h001, 8'hFF);
        rd_chk(A_SE, 8'h32);
    endtask

    // Each nonzero diff nibble clears only its own se nibble
    task t_clear();
        wr(A_SE, 8'hA7);
        wr(A_DIFF, 8'h30);
        rd_chk(A_SE, 8'h07);
        rd_chk(A_DIFF, 8'h30);
        wr(A_SE, 8'hA7);
        wr(A_DIFF, 8'h05);
        rd_chk(A_SE, 8'hA0);
        rd_chk(A_DIFF, 8'h05);
        wr(A_DIFF, 8'h00);
        rd_chk(A_SE, 8'hA0);
    endtask

    // Zero ranks never win; smallest nonzero rank does
    task t_select();
        wr(A_SE, 8'h12);
        sel_chk(4'hF, 1'b1, 2'h1);
        sel_chk(4'hD, 1'b1, 2'h0);
        sel_chk(4'hC, 1'b0, 2'h0);
        wr(A_DIFF, 8'h53);
        rd_chk(A_SE, 8'h00);
        sel_chk(4'hF, 1'b1, 2'h2);
        sel_chk(4'hB, 1'b1, 2'h3);
        rd_chk(A_STS, 8'hB7);
        wr(A_SE, 8'h31);
        repeat (2) @(posedge clk_i);
        chk_sel(1'b1, 2'h0);
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_unmapped();
        t_clear();
        t_select();
        finish_test();
    end
endmodule
